// [core/fru_defines.vh]
// Constants shared by the float rounding and NaN unit
`ifndef FRU_DEFINES_VH
`define FRU_DEFINES_VH

// ****************************************
// Rounding modes
// ****************************************
`define FRU_RM_NEAREST  2'h0
`define FRU_RM_PLUS     2'h1
`define FRU_RM_MINUS    2'h2
`define FRU_RM_ZERO     2'h3
`define FRU_RM_RESET    2'h0

// ****************************************
// Single precision format
// ****************************************
`define FRU_SIGN_BIT    31
`define FRU_EXP_HI      30
`define FRU_EXP_LO      23
`define FRU_FRAC_HI     22
`define FRU_QUIET_BIT   22
`define FRU_EXP_ALL1    8'hff
`define FRU_EXP_FULL    10'h0ff
`define FRU_FRAC_ZERO   23'h000000
`define FRU_FRAC_ALL1   23'h7fffff
`define FRU_MAX_EXP     8'hfe
`define FRU_MIN_EXP     8'h01
`define FRU_QNAN        32'h7fc00000

// ****************************************
// Register map and fields
// ****************************************
`define FRU_ADDR_PSW    12'h000
`define FRU_ADDR_SAVE   12'h004
`define FRU_ADDR_CTRL   12'h008
`define FRU_PSW_RM_LO   24
`define FRU_PSW_RM_HI   25
`define FRU_PSW_FX      26
`define FRU_PSW_FU      27
`define FRU_PSW_FV      29
`define FRU_PSW_FI      30
`define FRU_CTRL_TRAPEN 0

`endif

// [core/fru_opnd.v]
// Operand classifier: NaN kind and denormal flush for one operand
`include "fru_defines.vh"

module fru_opnd
(
	input  wire [31:0] op,
	input  wire        keep_denorm,
	output wire        is_snan,
	output wire        is_qnan,
	output wire [31:0] flushed
);
	wire exp_all1;
	wire exp_zero;
	wire frac_nz;

	assign exp_all1 = (op[`FRU_EXP_HI:`FRU_EXP_LO] == `FRU_EXP_ALL1);
	assign exp_zero = (op[`FRU_EXP_HI:`FRU_EXP_LO] == 8'h00);
	assign frac_nz  = (op[`FRU_FRAC_HI:0] != `FRU_FRAC_ZERO);

	// Quiet bit decides the NaN kind
	assign is_snan = exp_all1 & frac_nz & ~op[`FRU_QUIET_BIT];
	assign is_qnan = exp_all1 & frac_nz & op[`FRU_QUIET_BIT];

	// Denormals become signed zero except for compare
	assign flushed = (exp_zero & frac_nz & ~keep_denorm) ?
		{op[`FRU_SIGN_BIT], 31'h00000000} : op;
endmodule

// [core/fru_round.v]
// Single rounding step with tininess check and zero substitution
`include "fru_defines.vh"

module fru_round
(
	input  wire        sign,
	input  wire [9:0]  exp_in,
	input  wire [47:0] mant,
	input  wire        is_zero,
	input  wire        is_inf,
	input  wire [1:0]  mode,
	output reg  [31:0] res,
	output reg         ovf,
	output reg         unf,
	output reg         inx
);
	reg        tiny;
	reg [23:0] kept;
	reg        grd;
	reg        stk;
	reg        inc;
	reg [24:0] sum;
	reg [9:0]  exp_r;
	reg        to_inf;

	always @*
	begin
		tiny = $signed(exp_in) < $signed(10'h001);
		if (exp_in == 10'h000)
		begin
			kept = {1'b0, mant[47:25]};
			grd  = mant[24];
			stk  = |mant[23:0];
		end
		else
		begin
			kept = mant[47:24];
			grd  = mant[23];
			stk  = |mant[22:0];
		end
		case (mode)
			`FRU_RM_NEAREST: inc = grd & (stk | kept[0]);
			`FRU_RM_PLUS:    inc = ~sign & (grd | stk);
			`FRU_RM_MINUS:   inc = sign & (grd | stk);
			`FRU_RM_ZERO:    inc = 1'b0;
			default:         inc = 1'b0;
		endcase
		sum    = {1'b0, kept} + {24'h000000, inc};
		exp_r  = exp_in + {9'h000, sum[24]};
		to_inf = (mode == `FRU_RM_NEAREST) | (mode == `FRU_RM_PLUS & ~sign) |
			(mode == `FRU_RM_MINUS & sign);
		ovf = 1'b0;
		unf = 1'b0;
		inx = 1'b0;
		if (is_inf)
			res = {sign, `FRU_EXP_ALL1, `FRU_FRAC_ZERO};
		else if (is_zero)
			res = {sign, 31'h00000000};
		else if (tiny)
		begin
			// Round first, then any denormal outcome becomes signed zero
			unf = 1'b1;
			inx = 1'b1;
			if (exp_in == 10'h000 && sum[23])
				res = {sign, `FRU_MIN_EXP, `FRU_FRAC_ZERO};
			else
				res = {sign, 31'h00000000};
		end
		else if ($signed(exp_r) >= $signed(`FRU_EXP_FULL))
		begin
			ovf = 1'b1;
			inx = 1'b1;
			res = to_inf ? {sign, `FRU_EXP_ALL1, `FRU_FRAC_ZERO} :
				{sign, `FRU_MAX_EXP, `FRU_FRAC_ALL1};
		end
		else
		begin
			inx = grd | stk;
			res = {sign, exp_r[7:0], sum[24] ? sum[23:1] : sum[22:0]};
		end
	end
endmodule

// [core/fru_top.v]
// Float result shaping unit: NaN handling, rounding, sticky flags, mode save
//
// Summary of operation
// - NaN quiet when fraction bit 22 set
// - Invalid operation sets flag, returns quiet NaN, or zero for compare
// - Quiet NaN operands give fixed 7FC00000, compare gives zero
// - Tiny before rounding below 2^-126 flags underflow
// - Underflow flagged even for exact denormal
// - Fused multiply-add rounded only once
// - Mode from status bits 25:24
// - Default mode is round to nearest
// - Nearest mode returns closest value
// - Plus mode returns closest not below
// - Minus mode returns closest not above
// - Zero mode truncates toward zero
// - Flag update can change rounding mode
// - Round first, then denormal becomes signed zero
// - Call exit leaves mode unchanged
// - Exception or monitor exit restores mode
// - Traps asynchronous, results never altered
// - Denormal operands zeroed except for compare
// - Overflow or underflow also sets inexact
// - Exception flags are sticky
`include "fru_defines.vh"

module fru_top
(
	input  wire        CLK,
	input  wire        RESET,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	input  wire        ISSUE,
	input  wire [31:0] OPA,
	input  wire [31:0] OPB,
	input  wire [31:0] OPC,
	input  wire [2:0]  OPS_USED,
	input  wire        IS_CMP,
	input  wire        OP_INVALID,
	output reg  [31:0] OPA_FLUSHED,
	output reg  [31:0] OPB_FLUSHED,
	output reg  [31:0] OPC_FLUSHED,
	input  wire        RES_VALID,
	input  wire        RES_SIGN,
	input  wire [9:0]  RES_EXP,
	input  wire [47:0] RES_MANT,
	input  wire        RES_ZERO,
	input  wire        RES_INF,
	output reg  [31:0] RESULT,
	output reg         RESULT_VALID,
	input  wire        ENTRY_SAVE,
	input  wire        CALL_EXIT,
	input  wire        EXC_EXIT,
	input  wire        MON_EXIT,
	output reg  [1:0]  ROUND_SELECT,
	output reg  [3:0]  STICKY_FLAGS,
	output reg         TRAP_REQ
);
	// ****************************************
	// Declarations
	// ****************************************
	reg  [1:0]  round_select_q;
	reg  [1:0]  round_select_d;
	reg  [1:0]  saved_rm_q;
	reg  [1:0]  saved_rm_d;
	reg         invalid_op_flag_q;
	reg         overflow_flag_q;
	reg         underflow_flag_q;
	reg         inexact_flag_q;
	reg         invalid_op_flag_d;
	reg         overflow_flag_d;
	reg         underflow_flag_d;
	reg         inexact_flag_d;
	reg         trap_en_q;
	reg  [1:0]  issue_rm_q;
	reg         issue_inv_q;
	reg         issue_qnan_q;
	reg         issue_cmp_q;
	reg  [31:0] res_d;
	reg         fi_new;
	reg         fv_new;
	reg         fu_new;
	reg         fx_new;
	reg  [31:0] rdata_d;
	reg         map_hit;
	wire [95:0] ops_in;
	wire [95:0] ops_flushed;
	wire [2:0]  op_snan;
	wire [2:0]  op_qnan;
	wire        any_snan;
	wire        any_qnan;
	wire        setup;
	wire        wr_done;
	wire        wr_psw;
	wire        wr_save;
	wire        wr_ctrl;
	wire [31:0] rnd_res;
	wire        rnd_ovf;
	wire        rnd_unf;
	wire        rnd_inx;
	wire [31:0] psw_view;

	// ****************************************
	// Operand classification
	// ****************************************
	assign ops_in = {OPC, OPB, OPA};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_op
			fru_opnd u_opnd
			(
				.op          (ops_in[gi*32 +: 32]),
				.keep_denorm (IS_CMP),
				.is_snan     (op_snan[gi]),
				.is_qnan     (op_qnan[gi]),
				.flushed     (ops_flushed[gi*32 +: 32])
			);
		end
	endgenerate

	assign any_snan = |(op_snan & OPS_USED);
	assign any_qnan = |(op_qnan & OPS_USED);

	// ****************************************
	// Issue stage
	// ****************************************
	always @(posedge CLK)
	begin
		if (RESET)
		begin
			issue_rm_q   <= `FRU_RM_RESET;
			issue_inv_q  <= 1'b0;
			issue_qnan_q <= 1'b0;
			issue_cmp_q  <= 1'b0;
			OPA_FLUSHED  <= 32'h00000000;
			OPB_FLUSHED  <= 32'h00000000;
			OPC_FLUSHED  <= 32'h00000000;
		end
		else if (ISSUE)
		begin
			issue_rm_q   <= round_select_q;
			issue_inv_q  <= any_snan | OP_INVALID;
			issue_qnan_q <= any_qnan;
			issue_cmp_q  <= IS_CMP;
			OPA_FLUSHED  <= ops_flushed[31:0];
			OPB_FLUSHED  <= ops_flushed[63:32];
			OPC_FLUSHED  <= ops_flushed[95:64];
		end
	end

	// ****************************************
	// Rounding of the unrounded result
	// ****************************************
	// The mantissa arrives at full width, so a fused result is rounded here once
	fru_round u_round
	(
		.sign    (RES_SIGN),
		.exp_in  (RES_EXP),
		.mant    (RES_MANT),
		.is_zero (RES_ZERO),
		.is_inf  (RES_INF),
		.mode    (issue_rm_q),
		.res     (rnd_res),
		.ovf     (rnd_ovf),
		.unf     (rnd_unf),
		.inx     (rnd_inx)
	);

	always @*
	begin
		fi_new = 1'b0;
		fv_new = 1'b0;
		fu_new = 1'b0;
		fx_new = 1'b0;
		res_d  = rnd_res;
		if (RES_VALID)
		begin
			if (issue_inv_q)
			begin
				fi_new = 1'b1;
				res_d  = `FRU_QNAN;
			end
			else if (issue_qnan_q)
				res_d = `FRU_QNAN;
			else if (!issue_cmp_q)
			begin
				fv_new = rnd_ovf;
				fu_new = rnd_unf;
				fx_new = rnd_inx;
			end
			if (issue_cmp_q)
				res_d = 32'h00000000;
		end
	end

	// ****************************************
	// Result stage
	// ****************************************
	always @(posedge CLK)
	begin
		if (RESET)
		begin
			RESULT       <= 32'h00000000;
			RESULT_VALID <= 1'b0;
			TRAP_REQ     <= 1'b0;
		end
		else
		begin
			RESULT_VALID <= RES_VALID;
			if (RES_VALID)
				RESULT <= res_d;
			// Trap is a side request; the result above is never changed for it
			TRAP_REQ <= trap_en_q & (fi_new | fv_new | fu_new | fx_new);
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	assign setup   = PSEL & ~PENABLE;
	assign wr_done = PSEL & PENABLE & PREADY & PWRITE;
	assign wr_psw  = wr_done & (PADDR == `FRU_ADDR_PSW);
	assign wr_save = wr_done & (PADDR == `FRU_ADDR_SAVE);
	assign wr_ctrl = wr_done & (PADDR == `FRU_ADDR_CTRL);

	assign psw_view = {1'b0, invalid_op_flag_q, overflow_flag_q, 1'b0, underflow_flag_q,
		inexact_flag_q, round_select_q, 24'h000000};

	always @*
	begin
		map_hit = 1'b1;
		case (PADDR)
			`FRU_ADDR_PSW:  rdata_d = psw_view;
			`FRU_ADDR_SAVE: rdata_d = {30'h00000000, saved_rm_q};
			`FRU_ADDR_CTRL: rdata_d = {31'h00000000, trap_en_q};
			default:
			begin
				rdata_d = 32'h00000000;
				map_hit = 1'b0;
			end
		endcase
	end

	always @(posedge CLK)
	begin
		if (RESET)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end
		else
		begin
			PREADY  <= setup;
			PSLVERR <= setup & ~map_hit;
			if (setup && !PWRITE)
				PRDATA <= rdata_d;
		end
	end

	// ****************************************
	// Rounding mode, saved copy and control
	// ****************************************
	always @*
	begin
		round_select_d = round_select_q;
		saved_rm_d     = saved_rm_q;
		if (wr_psw)
			round_select_d = PWDATA[`FRU_PSW_RM_HI:`FRU_PSW_RM_LO];
		if (wr_save)
			saved_rm_d = PWDATA[1:0];
		if (ENTRY_SAVE)
			saved_rm_d = round_select_q;
		// Call exit has its own branch here, which keeps round_select_d as it is
		if (EXC_EXIT || MON_EXIT)
			round_select_d = saved_rm_q;
		else if (CALL_EXIT)
			round_select_d = round_select_d;
	end

	always @(posedge CLK)
	begin
		if (RESET)
		begin
			round_select_q <= `FRU_RM_RESET;
			saved_rm_q     <= `FRU_RM_RESET;
			trap_en_q      <= 1'b0;
		end
		else
		begin
			round_select_q <= round_select_d;
			saved_rm_q     <= saved_rm_d;
			if (wr_ctrl)
				trap_en_q <= PWDATA[`FRU_CTRL_TRAPEN];
		end
	end

	// ****************************************
	// Sticky exception flags
	// ****************************************
	// A new exception in the same cycle as a software write keeps its flag
	always @*
	begin
		invalid_op_flag_d = (wr_psw ? PWDATA[`FRU_PSW_FI] : invalid_op_flag_q) |
			fi_new;
		overflow_flag_d   = (wr_psw ? PWDATA[`FRU_PSW_FV] : overflow_flag_q) |
			fv_new;
		underflow_flag_d  = (wr_psw ? PWDATA[`FRU_PSW_FU] : underflow_flag_q) |
			fu_new;
		inexact_flag_d    = (wr_psw ? PWDATA[`FRU_PSW_FX] : inexact_flag_q) |
			fx_new;
	end

	always @(posedge CLK)
	begin
		if (RESET)
		begin
			invalid_op_flag_q <= 1'b0;
			overflow_flag_q   <= 1'b0;
			underflow_flag_q  <= 1'b0;
			inexact_flag_q    <= 1'b0;
		end
		else
		begin
			invalid_op_flag_q <= invalid_op_flag_d;
			overflow_flag_q   <= overflow_flag_d;
			underflow_flag_q  <= underflow_flag_d;
			inexact_flag_q    <= inexact_flag_d;
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	always @(posedge CLK)
	begin
		if (RESET)
		begin
			ROUND_SELECT <= `FRU_RM_RESET;
			STICKY_FLAGS <= 4'h0;
		end
		else
		begin
			ROUND_SELECT <= round_select_d;
			STICKY_FLAGS <= {invalid_op_flag_d, overflow_flag_d, underflow_flag_d,
				inexact_flag_d};
		end
	end
endmodule

// [bench/fru_monitor.sv]
// Port checker for the float result shaping unit
module fru_monitor
(
	input wire        CLK,
	input wire        RESET,
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire        PREADY,
	input wire        PSLVERR,
	input wire        RES_VALID,
	input wire        RESULT_VALID,
	input wire [31:0] RESULT,
	input wire [3:0]  STICKY_FLAGS,
	input wire [1:0]  ROUND_SELECT,
	input wire        ENTRY_SAVE,
	input wire        CALL_EXIT,
	input wire        EXC_EXIT,
	input wire        MON_EXIT
);
	timeunit 1ns/1ps;
	logic [1:0] saved_q;
	logic       wr;
	logic       wr_psw;
	assign wr = PSEL && PENABLE && PREADY && PWRITE;
	assign wr_psw = wr && PADDR == 12'h000;

	// ****
	// Saved mode copy
	// ****
	always_ff @(posedge CLK)
		if (RESET)
			saved_q <= 2'h0;
		else if (ENTRY_SAVE)
			saved_q <= ROUND_SELECT;
		else if (wr && PADDR == 12'h004)
			saved_q <= PWDATA[1:0];

	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_access;
		PREADY ##1 !PREADY;
	endsequence

	a_ready_pulse: assert property (s_setup |=> s_access)
		else $error("Ready not one cycle after setup");
	a_err_map: assert property (PREADY |-> PSLVERR == !(PADDR inside {12'h0, 12'h4, 12'h8}))
		else $error("Slave error mismatch");
	a_result_next: assert property (RES_VALID |=> RESULT_VALID)
		else $error("Result valid late");
	a_flags_sticky: assert property (!wr_psw |=>
		(STICKY_FLAGS & $past(STICKY_FLAGS)) == $past(STICKY_FLAGS))
		else $error("Sticky flag dropped");
	a_ovf_inexact: assert property (RESULT_VALID && $rose(|STICKY_FLAGS[2:1]) |->
		STICKY_FLAGS[0])
		else $error("Inexact missing");
	a_nan_fixed: assert property (RESULT_VALID && $rose(STICKY_FLAGS[3]) |->
		RESULT inside {32'h7fc00000, 32'h0})
		else $error("Invalid result wrong");
	a_tiny_zero: assert property (RESULT_VALID && $rose(STICKY_FLAGS[1]) |->
		RESULT[30:0] inside {31'h0, 31'h00800000})
		else $error("Tiny result wrong");
	a_call_keep: assert property (CALL_EXIT && !EXC_EXIT && !MON_EXIT && !wr |=>
		$stable(ROUND_SELECT))
		else $error("Mode changed on call exit");
	a_exit_restore: assert property (EXC_EXIT || MON_EXIT |=>
		ROUND_SELECT == $past(saved_q))
		else $error("Mode not restored");
	a_mode_write: assert property (wr_psw && !EXC_EXIT && !MON_EXIT |=>
		ROUND_SELECT == $past(PWDATA[25:24]))
		else $error("Mode write lost");
endmodule

bind fru_top fru_monitor u_mon (.*);

// [bench/fru_core_model.sv]
// Issue side model driving instructions and unrounded results
module fru_core_model
(
	input  logic        CLK,
	output logic        ISSUE,
	output logic [31:0] OPA,
	output logic [31:0] OPB,
	output logic [31:0] OPC,
	output logic [2:0]  OPS_USED,
	output logic        IS_CMP,
	output logic        OP_INVALID,
	output logic        RES_VALID,
	output logic        RES_SIGN,
	output logic [9:0]  RES_EXP,
	output logic [47:0] RES_MANT,
	output logic        RES_ZERO,
	output logic        RES_INF,
	output logic        ENTRY_SAVE,
	output logic        CALL_EXIT,
	output logic        EXC_EXIT,
	output logic        MON_EXIT
);
	timeunit 1ns/1ps;
	initial
	begin
		{ISSUE, OPA, OPB, OPC, OPS_USED, IS_CMP, OP_INVALID} = '0;
		{RES_VALID, RES_SIGN, RES_EXP, RES_MANT, RES_ZERO, RES_INF} = '0;
		{ENTRY_SAVE, CALL_EXIT, EXC_EXIT, MON_EXIT} = '0;
	end

	// Issue, wait, then hand back the result
	task automatic op(input logic [31:0] a, input logic c, v, input logic [10:0] se,
		input logic [47:0] m, input int w, input logic [1:0] zi);
		@(posedge CLK);
		ISSUE <= 1'b1;
		OPA <= a;
		OPB <= 32'h3f800000;
		OPC <= ~a;
		OPS_USED <= 3'h3;
		IS_CMP <= c;
		OP_INVALID <= v;
		@(posedge CLK);
		ISSUE <= 1'b0;
		repeat (w) @(posedge CLK);
		RES_VALID <= 1'b1;
		{RES_SIGN, RES_EXP} <= se;
		RES_MANT <= m;
		{RES_ZERO, RES_INF} <= zi;
		@(posedge CLK);
		RES_VALID <= 1'b0;
		RES_MANT <= ~m;
		{RES_ZERO, RES_INF} <= 2'h0;
	endtask

	// One pulse of save, call exit, exception exit, monitor exit
	task automatic exits(input logic [3:0] k);
		@(posedge CLK);
		{ENTRY_SAVE, CALL_EXIT, EXC_EXIT, MON_EXIT} <= k;
		@(posedge CLK);
		{ENTRY_SAVE, CALL_EXIT, EXC_EXIT, MON_EXIT} <= 4'h0;
	endtask
endmodule

// [bench/fru_top_tb.sv]
// Self-checking bench for the float result shaping unit
module fru_top_tb;
	timeunit 1ns/1ps;
	logic        CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err_q;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, OPA, OPB, OPC, OPA_FLUSHED, OPB_FLUSHED, OPC_FLUSHED;
	logic [31:0] RESULT, rd_q;
	logic [47:0] RES_MANT;
	logic [9:0]  RES_EXP;
	logic [3:0]  STICKY_FLAGS;
	logic [2:0]  OPS_USED;
	logic [1:0]  ROUND_SELECT;
	logic        ISSUE, IS_CMP, OP_INVALID, RES_VALID, RES_SIGN, RES_ZERO, RES_INF;
	logic        RESULT_VALID, ENTRY_SAVE, CALL_EXIT, EXC_EXIT, MON_EXIT, TRAP_REQ;
	int          compares, miscompares;

	fru_top        dut (.*);
	fru_core_model core (.*);

	always #20 CLK = ~CLK;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("Compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do
			@(posedge CLK);
		while (PREADY !== 1'b1);
		rd_q = PRDATA;
		err_q = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic mode(input logic [1:0] m);
		apb(1'b1, 12'h000, {6'h0, m, 24'h0});
	endtask

	task automatic res(input logic [31:0] a, input logic c, v, input logic [10:0] se,
		input logic [47:0] m, input logic [31:0] er, input logic [3:0] ef,
		input logic [1:0] zi = 2'h0);
		core.op(a, c, v, se, m, compares % 3, zi);
		@(negedge CLK);
		chk(RESULT, er);
		chk(32'(STICKY_FLAGS), 32'(ef));
	endtask

	initial
	begin
		logic [1:0] md;
		logic       s;
		logic       up;
		CLK = 1'b0;
		RESET = 1'b1;
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		compares = 0;
		miscompares = 0;
		repeat (5) @(posedge CLK);
		RESET <= 1'b0;
		@(negedge CLK);
		chk(32'(ROUND_SELECT), 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			md = i[1:0];
			s = i[2];
			up = md == 2'h0 || md == {s, ~s};
			mode(md);
			res(32'h3f800000, 0, 0, {s, 10'h07f}, 48'h800001_c00000,
				{s, 8'h7f, 23'h1 + 23'(up)}, 4'h1);
		end
		res(32'h3f800000, 0, 0, 11'h07f, 48'h800000_000000, 32'h3f800000, 4'h1);
		mode(2'h0);
		res(32'h3f800000, 0, 0, 11'h07f, 48'h800000_800001, 32'h3f800001, 4'h1);
		mode(2'h3);
		res(32'h3f800000, 0, 0, 11'h400, 48'h800000_000000, 32'h80000000, 4'h3);
		mode(2'h0);
		res(32'h3f800000, 0, 0, 11'h000, 48'hffffff_ffffff, 32'h00800000, 4'h3);
		mode(2'h3);
		res(32'h3f800000, 0, 0, 11'h0ff, 48'h800000_000000, 32'h7f7fffff, 4'h5);
		mode(2'h0);
		res(32'h7f800001, 0, 0, 11'h07f, 48'h800000_000000, 32'h7fc00000, 4'h8);
		mode(2'h0);
		res(32'h7fc12345, 0, 0, 11'h07f, 48'h800000_000000, 32'h7fc00000, 4'h0);
		res(32'h3f800000, 0, 0, 11'h400, 48'h800000_000000, 32'hff800000, 4'h0, 2'h1);
		res(32'h3f800000, 0, 0, 11'h400, 48'h800000_000000, 32'h80000000, 4'h0, 2'h2);
		res(32'h80000123, 0, 1, 11'h07f, 48'h800000_000000, 32'h7fc00000, 4'h8);
		chk(OPA_FLUSHED, 32'h80000000);
		chk(OPB_FLUSHED, 32'h3f800000);
		chk(OPC_FLUSHED, 32'h7ffffedc);
		res(32'h80000123, 1, 0, 11'h07f, 48'h800000_000000, 32'h0, 4'h8);
		chk(OPA_FLUSHED, 32'h80000123);
		mode(2'h2);
		core.exits(4'h8);
		mode(2'h3);
		core.exits(4'h4);
		@(negedge CLK);
		chk(32'(ROUND_SELECT), 32'h3);
		core.exits(4'h2);
		@(negedge CLK);
		chk(32'(ROUND_SELECT), 32'h2);
		mode(2'h1);
		core.exits(4'h1);
		@(negedge CLK);
		chk(32'(ROUND_SELECT), 32'h2);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd_q, 32'h00000002);
		chk(32'(err_q), 32'h0);
		apb(1'b1, 12'h000, 32'hffffffff);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd_q, 32'h6f000000);
		apb(1'b1, 12'h00c, 32'hffffffff);
		chk(32'(err_q), 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd_q, 32'h0);
		apb(1'b1, 12'h008, 32'h1);
		mode(2'h0);
		res(32'h3f800000, 0, 0, 11'h07f, 48'h800000_000001, 32'h3f800000, 4'h1);
		chk(32'(TRAP_REQ), 32'h1);
		@(negedge CLK);
		chk(32'(TRAP_REQ), 32'h0);
		stop_test;
	end

	initial
	begin
		#100000;
		miscompares++;
		stop_test;
	end
endmodule
